// >>> bench/fsps_core_tb.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/10ps
`include "fsps_defs.svh"
module fsps_core_tb;
  localparam int PROG = 20;
  logic sys_clk, srst, power_on, data_code_protect, prog_code_protect;
  logic [1:0] self_protect_bits;
  logic hsel, hwrite, hreadyout, hresp, cpu_stall, cpu_discard;
  logic flash_erase, flash_program;
  logic ext_data_access_ok, ext_prog_access_ok, ext_prog_write_ok;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [10:0] flash_row_addr;
  logic [13:0] flash_block_addr;
  logic [55:0] flash_block_data;
  logic [7:0] q;
  logic [31:0] q32;
  int err_total = 0;
  int samples_checked = 0;

  // ********************************************************
  // Clock, design and CPU model
  // ********************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Short program and lockout counts keep the run brief
  fsps_core #(.PROG_CYCLES(PROG), .PWRT_CYCLES(30)) u_fsps_core (
    .sys_clk(sys_clk), .srst(srst), .power_on(power_on),
    .self_protect_bits(self_protect_bits),
    .data_code_protect(data_code_protect),
    .prog_code_protect(prog_code_protect), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_stall(cpu_stall), .cpu_discard(cpu_discard),
    .flash_erase(flash_erase), .flash_program(flash_program),
    .flash_row_addr(flash_row_addr), .flash_block_addr(flash_block_addr),
    .flash_block_data(flash_block_data),
    .ext_data_access_ok(ext_data_access_ok),
    .ext_prog_access_ok(ext_prog_access_ok),
    .ext_prog_write_ok(ext_prog_write_ok));

  fsps_cpu_model u_fsps_cpu_model (
    .sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // ********************************************************
  // Shared checks
  // ********************************************************
  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : compare

  // Any sign of a started cycle over k cycles
  task automatic count_busy(input int k, output logic b);
    b = 1'b0;
    repeat (k)
    begin
      @(posedge sys_clk);
      #1;
      b = b | cpu_stall | cpu_discard | flash_program | flash_erase;
    end
  endtask : count_busy

  // A refused go leaves the CPU running and go clear
  task automatic no_launch;
    logic b;
    count_busy(30, b);
    compare(64'(b), 64'h0);
    u_fsps_cpu_model.rd(`FSPS_IDX_CTL, q);
    compare(64'(q[1]), 64'h0);
  endtask : no_launch

  // Discard slots, latched target, stall length, then done flag and go
  task automatic launch(input logic [2:0] disc, input logic [1:0] kind,
                        input logic [13:0] loc, input logic [55:0] data);
    int n;
    // First slot is the cycle right after the go write
    for (int i = 0; i < 3; i++)
    begin
      if (i > 0)
        @(posedge sys_clk);
      #1;
      compare(64'(cpu_discard), 64'(disc[i]));
    end
    compare(64'({cpu_stall, flash_erase, flash_program}),
            64'({1'b1, kind}));
    if (kind == 2'b10)
      compare(64'(flash_row_addr), 64'(loc[10:0]));
    else
      compare(64'(flash_block_addr), 64'(loc));
    if (kind == 2'b01)
      compare(64'(flash_block_data), 64'(data));
    n = 0;
    while (cpu_stall === 1'b1 && n < 1000)
    begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    compare(64'(n), 64'(PROG));
    u_fsps_cpu_model.rd(`FSPS_IDX_FLAG2, q);
    compare(64'(q), 64'h10);
    u_fsps_cpu_model.rd(`FSPS_IDX_CTL, q);
    compare(64'(q[1]), 64'h0);
    u_fsps_cpu_model.wr(`FSPS_IDX_FLAG2, 8'h00);
  endtask : launch

  // ********************************************************
  // Scenarios
  // ********************************************************

  // Reset values, enable write-back, unmapped place, enable held clear
  task automatic test_reset;
    u_fsps_cpu_model.rd(`FSPS_IDX_FLAG2, q);
    compare(64'(q), 64'h0);
    u_fsps_cpu_model.wr(`FSPS_IDX_ENA2, 8'h10);
    u_fsps_cpu_model.rd(`FSPS_IDX_ENA2, q);
    compare(64'(q), 64'h10);
    u_fsps_cpu_model.bus(1'b1, 32'h0000_0800, 32'h0000_00FF, q32);
    u_fsps_cpu_model.bus(1'b0, 32'h0000_0800, 32'h0, q32);
    compare(64'({hresp, q32}), 64'h0);
    u_fsps_cpu_model.wr(`FSPS_IDX_CTL, 8'h84);
    u_fsps_cpu_model.rd(`FSPS_IDX_CTL, q);
    compare(64'(q[2]), 64'h0);
    $display("reset test done");
  endtask : test_reset

  // Refused go: lockout, enable clear, keys swapped, keys split
  task automatic test_refuse;
    u_fsps_cpu_model.prog_word(16'h0123, 14'h0000, 8'h96);
    no_launch();
    u_fsps_cpu_model.wr(`FSPS_IDX_CTL, 8'h80);
    u_fsps_cpu_model.wr(`FSPS_IDX_KEY, `FSPS_KEY_FIRST);
    u_fsps_cpu_model.wr(`FSPS_IDX_KEY, `FSPS_KEY_SECOND);
    u_fsps_cpu_model.wr(`FSPS_IDX_CTL, 8'h96);
    no_launch();
    u_fsps_cpu_model.wr(`FSPS_IDX_CTL, 8'h84);
    u_fsps_cpu_model.wr(`FSPS_IDX_KEY, `FSPS_KEY_SECOND);
    u_fsps_cpu_model.wr(`FSPS_IDX_KEY, `FSPS_KEY_FIRST);
    u_fsps_cpu_model.wr(`FSPS_IDX_CTL, 8'h96);
    no_launch();
    u_fsps_cpu_model.wr(`FSPS_IDX_KEY, `FSPS_KEY_FIRST);
    u_fsps_cpu_model.wr(`FSPS_IDX_DATA_LO, 8'h00);
    u_fsps_cpu_model.wr(`FSPS_IDX_KEY, `FSPS_KEY_SECOND);
    u_fsps_cpu_model.wr(`FSPS_IDX_CTL, 8'h96);
    no_launch();
    $display("refusal test done");
  endtask : test_refuse

  // Row erase, four-word block, then a block with only the last word
  task automatic test_program;
    logic [55:0] w;
    logic b;
    w = 56'h01_2C3E_15A2_0A51;
    u_fsps_cpu_model.prog_word(16'h0123, 14'h0000, 8'h96);
    launch(3'b011, 2'b10, 14'h0009, 56'h0);
    for (int i = 0; i < 3; i++)
    begin
      u_fsps_cpu_model.prog_word(16'h0100 + 16'(i), w[14*i +: 14],
                                 8'h86);
      count_busy(4, b);
      compare(64'(b), 64'h0);
    end
    u_fsps_cpu_model.rd(`FSPS_IDX_FLAG2, q);
    compare(64'(q), 64'h0);
    u_fsps_cpu_model.prog_word(16'h0103, w[55:42], 8'h86);
    launch(3'b010, 2'b01, 14'h0040, w);
    u_fsps_cpu_model.prog_word(16'h0107, 14'h1234, 8'h86);
    launch(3'b010, 2'b01, 14'h0041, {14'h1234, {3{14'h3FFF}}});
    $display("program test done");
  endtask : test_program

  // Protect boundary, then code-protect straps on the access flags
  task automatic test_protect;
    logic [5:0] cp;
    logic [8:0] ex;
    cp = {2'b00, 2'b10, 2'b01};
    ex = {3'b111, 3'b100, 3'b010};
    self_protect_bits <= 2'b00;
    repeat (4) @(posedge sys_clk);
    u_fsps_cpu_model.prog_word(16'h07FF, 14'h0000, 8'h86);
    no_launch();
    u_fsps_cpu_model.prog_word(16'h0803, 14'h0155, 8'h86);
    launch(3'b010, 2'b01, 14'h0200, {14'h0155, {3{14'h3FFF}}});
    self_protect_bits <= 2'b11;
    for (int i = 0; i < 3; i++)
    begin
      {prog_code_protect, data_code_protect} <= cp[2*i +: 2];
      repeat (4) @(posedge sys_clk);
      #1;
      compare(64'({ext_data_access_ok, ext_prog_access_ok,
                   ext_prog_write_ok}), 64'(ex[3*i +: 3]));
      @(posedge sys_clk);
    end
    $display("protect test done");
  endtask : test_protect

  // Reset in mid-erase marks the abort flag; an idle reset keeps it
  task automatic test_abort;
    int n;
    u_fsps_cpu_model.prog_word(16'h0040, 14'h0000, 8'h96);
    n = 0;
    while (cpu_stall !== 1'b1 && n < 10)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      u_fsps_cpu_model.rd(`FSPS_IDX_CTL, q);
      compare(64'({cpu_stall, q[3]}), 64'h1);
    end
    $display("abort test done");
  endtask : test_abort

  // ********************************************************
  // Run control
  // ********************************************************
  task automatic end_sim;
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Hang guard: counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    $display("Error at %0t: got 0 expected 1 (timeout)", $time);
    end_sim();
  end

  // Power-up with lockout pending, then the scenarios in turn
  initial
  begin
    srst = 1'b1;
    power_on = 1'b1;
    self_protect_bits = 2'b11;
    data_code_protect = 1'b0;
    prog_code_protect = 1'b0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    test_reset();
    power_on <= 1'b0;
    test_refuse();
    test_program();
    test_protect();
    test_abort();
    end_sim();
  end
endmodule : fsps_core_tb

// >>> bench/fsps_cpu_model.sv
// Behavioural CPU core driving the sequencer registers over AHB-Lite
`timescale 1ns/10ps
`include "fsps_defs.svh"
module fsps_cpu_model (
  input wire logic sys_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ********************************************************
  // Bus cycles
  // ********************************************************

  // Idle bus at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end

  // Register index to byte address
  function automatic logic [31:0] ba(input logic [8:0] idx);
    return {21'h000000, idx, 2'h0};
  endfunction : ba

  // One single word transfer; a hung slave is left to the bench watchdog
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do
      @(posedge sys_clk);
    while (!hready);
    // Released address shows a stale-looking pattern, never the old value
    htrans <= 2'b00;
    hsel <= 1'b0;
    haddr <= ~a;
    hwdata <= d;
    do
      @(posedge sys_clk);
    while (!hready);
    q = hrdata;
    hwdata <= ~d;
  endtask : bus

  // Byte-wide register helpers
  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, ba(idx), {24'h000000, d}, q);
  endtask : wr

  task automatic rd(input logic [8:0] idx, output logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, ba(idx), 32'h0, q);
    d = q[7:0];
  endtask : rd

  // ********************************************************
  // Self-program instruction sequence
  // ********************************************************

  // Address, data, mode bits, both keys, then go; one call per word
  task automatic prog_word(input logic [15:0] a, input logic [13:0] w,
                           input logic [7:0] ctl);
    wr(`FSPS_IDX_ADDR_HI, a[15:8]);
    wr(`FSPS_IDX_ADDR_LO, a[7:0]);
    wr(`FSPS_IDX_DATA_LO, w[7:0]);
    wr(`FSPS_IDX_DATA_HI, {2'h0, w[13:8]});
    wr(`FSPS_IDX_CTL, ctl & 8'hFD);
    wr(`FSPS_IDX_KEY, `FSPS_KEY_FIRST);
    wr(`FSPS_IDX_KEY, `FSPS_KEY_SECOND);
    wr(`FSPS_IDX_CTL, ctl);
  endtask : prog_word
endmodule : fsps_cpu_model

// >>> hdl/fsps_core.sv
// Self-program sequencer for on-chip program memory, AHB-Lite slave
`timescale 1ns/10ps
`include "fsps_defs.svh"
module fsps_core
  import fsps_pkg::*;
#(
  parameter int PROG_CYCLES = `FSPS_PROG_CYCLES,
  parameter int PWRT_CYCLES = `FSPS_PWRT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic power_on,
  input wire logic [1:0] self_protect_bits,
  input wire logic data_code_protect,
  input wire logic prog_code_protect,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic cpu_stall,
  output logic cpu_discard,
  output logic flash_erase,
  output logic flash_program,
  output logic [10:0] flash_row_addr,
  output logic [13:0] flash_block_addr,
  output logic [55:0] flash_block_data,
  output logic ext_data_access_ok,
  output logic ext_prog_access_ok,
  output logic ext_prog_write_ok
);

  // ******************************************************
  // Functions
  // ******************************************************

  // True when the protect bits guard the given word address
  function automatic logic wp_blocks(input logic [15:0] a,
                                     input logic [1:0] bits);
    unique case (bits)
      2'b11: wp_blocks = 1'b0;
      2'b10: wp_blocks = (a < `FSPS_WP_LIMIT_10);
      2'b01: wp_blocks = (a < `FSPS_WP_LIMIT_01);
      2'b00: wp_blocks = (a < `FSPS_WP_LIMIT_00);
    endcase
  endfunction : wp_blocks

  // ******************************************************
  // Declarations
  // ******************************************************
  logic [4:0] pins_sync;
  logic por_s;
  logic [1:0] wp_s;
  logic dp_valid, dp_write, dp_mapped;
  logic [8:0] dp_idx;
  logic wr_en, wr_ctl, wr_key;
  logic [7:0] data_lo, data_hi, addr_lo, addr_hi, ena2;
  logic ctl_pgd, ctl_free, ctl_program_unlock_enable, ctl_abort, go, done_flag;
  fsps_key_t key;
  fsps_seq_t state, next_state;
  logic [15:0] word_addr;
  logic [13:0] wdata;
  logic [13:0] wbuf [4];
  logic start_ok, start_short, start_long, start_erase, op_erase;
  logic tmr_load, tmr_expire, pwrt_running, busy_now;
  logic [7:0] rd_mux;

  assign por_s = pins_sync[4];
  assign wp_s = pins_sync[3:2];
  assign word_addr = {addr_hi, addr_lo};
  assign wdata = {data_hi[5:0], data_lo};

  // Config straps and power-on level come from pins
  fsps_sync #(.W(5)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin({power_on, self_protect_bits, data_code_protect,
          prog_code_protect}),
    .level(pins_sync)
  );

  // ******************************************************
  // AHB-Lite slave
  // ******************************************************

  // Address phase capture; only aligned word accesses are mapped
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_mapped <= 1'b0;
      dp_idx <= 9'h000;
    end
    else
    begin
      dp_valid <= hsel && htrans[1] && hready;
      dp_write <= hwrite;
      dp_mapped <= (haddr[31:11] == 21'h000000) && (haddr[1:0] == 2'b00)
                   && (hsize == 3'b010);
      dp_idx <= haddr[10:2];
    end
  end

  assign wr_en = dp_valid && dp_write && dp_mapped;
  assign wr_ctl = wr_en && (dp_idx == `FSPS_IDX_CTL);
  assign wr_key = wr_en && (dp_idx == `FSPS_IDX_KEY);

  // Read view; the key register is write-only and reads zero
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (haddr[10:2])
      `FSPS_IDX_FLAG2: rd_mux[`FSPS_DONE_BIT] = done_flag;
      `FSPS_IDX_ENA2: rd_mux = ena2;
      `FSPS_IDX_DATA_LO: rd_mux = data_lo;
      `FSPS_IDX_ADDR_LO: rd_mux = addr_lo;
      `FSPS_IDX_DATA_HI: rd_mux = {2'b00, data_hi[5:0]};
      `FSPS_IDX_ADDR_HI: rd_mux = addr_hi;
      `FSPS_IDX_CTL: rd_mux = {ctl_pgd, 2'b00, ctl_free, ctl_abort,
                                ctl_program_unlock_enable, go, 1'b0};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data registered in the address phase: zero wait, always OKAY
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel && htrans[1] && hready && !hwrite &&
          haddr[31:11] == 21'h000000 && haddr[1:0] == 2'b00)
        hrdata <= {24'h000000, rd_mux};
      else
        hrdata <= 32'h00000000;
    end
  end

  // ******************************************************
  // Registers
  // ******************************************************

  // Plain data and address holders
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      data_lo <= `FSPS_REG_RESET;
      data_hi <= `FSPS_REG_RESET;
      addr_lo <= `FSPS_REG_RESET;
      addr_hi <= `FSPS_REG_RESET;
      ena2 <= `FSPS_REG_RESET;
    end
    else if (wr_en)
    begin
      unique case (dp_idx)
        `FSPS_IDX_DATA_LO: data_lo <= hwdata[7:0];
        `FSPS_IDX_DATA_HI: data_hi <= {2'b00, hwdata[5:0]};
        `FSPS_IDX_ADDR_LO: addr_lo <= hwdata[7:0];
        `FSPS_IDX_ADDR_HI: addr_hi <= hwdata[7:0];
        `FSPS_IDX_ENA2: ena2 <= {3'b000, hwdata[4], 4'h0};
        default: ;
      endcase
    end
  end

  // Control bits; write enable also drops on every power-on
  always_ff @(posedge sys_clk)
  begin
    if (srst || por_s)
    begin
      ctl_pgd <= 1'b0;
      ctl_free <= 1'b0;
      ctl_program_unlock_enable <= 1'b0;
    end
    else if (wr_ctl)
    begin
      ctl_pgd <= hwdata[`FSPS_CTL_PGD];
      ctl_free <= hwdata[`FSPS_CTL_FREE];
      ctl_program_unlock_enable <= hwdata[`FSPS_CTL_PROGRAM_UNLOCK_ENABLE];
    end
  end

  // Abort flag survives a warm reset and records a cut-off cycle
  always_ff @(posedge sys_clk)
  begin
    if (por_s)
      ctl_abort <= 1'b0;
    else if (srst && busy_now)
      ctl_abort <= 1'b1;
    else if (wr_ctl && !srst)
      ctl_abort <= hwdata[`FSPS_CTL_ABORT];
  end

  // Done flag: hardware set wins over a software clear
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      done_flag <= 1'b0;
    else if (state == SEQ_BUSY && tmr_expire)
      done_flag <= 1'b1;
    else if (wr_en && dp_idx == `FSPS_IDX_FLAG2)
      done_flag <= hwdata[`FSPS_DONE_BIT];
  end

  // ******************************************************
  // Unlock sequence
  // ******************************************************

  // Any write out of order drops the arming
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      key <= KEY_IDLE;
    else if (wr_key && hwdata[7:0] == `FSPS_KEY_FIRST)
      key <= KEY_FIRST;
    else if (wr_key && hwdata[7:0] == `FSPS_KEY_SECOND && key == KEY_FIRST)
      key <= KEY_ARMED;
    else if (wr_en)
      key <= KEY_IDLE;
  end

  // Start needs keys, enable, no lockout and an unprotected address
  assign start_ok = wr_ctl && hwdata[`FSPS_CTL_GO] && !go &&
                    key == KEY_ARMED &&
                    ctl_program_unlock_enable &&
                    !pwrt_running &&
                    hwdata[`FSPS_CTL_PGD] &&
                    !wp_blocks(word_addr, wp_s);
  assign start_erase = start_ok && hwdata[`FSPS_CTL_FREE];
  assign start_short = start_ok && !hwdata[`FSPS_CTL_FREE] &&
                       addr_lo[1:0] != 2'b11;
  assign start_long = start_ok && !hwdata[`FSPS_CTL_FREE] &&
                      addr_lo[1:0] == 2'b11;

  // ******************************************************
  // Sequencer
  // ******************************************************

  // Cycle timer and power-up lockout share one counter design
  fsps_timer #(.W(24)) u_prog_tmr (
    .sys_clk(sys_clk),
    .srst(srst),
    .load(tmr_load),
    .count(24'(PROG_CYCLES)),
    .running(),
    .expire(tmr_expire)
  );

  fsps_timer #(.W(24)) u_pwrt (
    .sys_clk(sys_clk),
    .srst(srst),
    .load(por_s),
    .count(24'(PWRT_CYCLES)),
    .running(pwrt_running),
    .expire()
  );

  assign tmr_load = (state != SEQ_BUSY) && (next_state == SEQ_BUSY);
  assign busy_now = (state == SEQ_BUSY);

  // Next state: erase discards two slots, long write only the second
  always_comb
  begin
    next_state = state;
    unique case (state)
      SEQ_IDLE:
        if (start_erase)
          next_state = SEQ_SETUP;
        else if (start_long)
          next_state = SEQ_EXEC;
        else if (start_short)
          next_state = SEQ_SHORT;
      SEQ_SHORT: next_state = SEQ_IDLE;
      SEQ_SETUP: next_state = SEQ_DISCARD;
      SEQ_EXEC: next_state = SEQ_DISCARD;
      SEQ_DISCARD: next_state = SEQ_BUSY;
      SEQ_BUSY:
        if (tmr_expire)
          next_state = SEQ_IDLE;
      default: next_state = SEQ_IDLE;
    endcase
  end

  // State and the go bit, cleared by hardware on return to idle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state <= SEQ_IDLE;
      go <= 1'b0;
      op_erase <= 1'b0;
    end
    else
    begin
      state <= next_state;
      go <= (next_state != SEQ_IDLE);
      if (state == SEQ_IDLE && start_ok)
        op_erase <= hwdata[`FSPS_CTL_FREE];
    end
  end

  // CPU halt and discard; clocks keep running, no sleep entry
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cpu_stall <= 1'b0;
      cpu_discard <= 1'b0;
      flash_erase <= 1'b0;
      flash_program <= 1'b0;
    end
    else
    begin
      cpu_stall <= (next_state == SEQ_BUSY);
      cpu_discard <= (next_state == SEQ_SETUP) ||
                     (next_state == SEQ_DISCARD);
      flash_erase <= (next_state == SEQ_BUSY) && op_erase;
      flash_program <= (next_state == SEQ_BUSY) && !op_erase;
    end
  end

  // Row and block addresses; the low bits are dropped here, before the array
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      flash_row_addr <= 11'h000;
      flash_block_addr <= 14'h0000;
      flash_block_data <= {4{`FSPS_BUF_ERASED}};
    end
    else if (state == SEQ_IDLE && start_ok)
    begin
      flash_row_addr <= word_addr[15:5];
      flash_block_addr <= word_addr[15:2];
      flash_block_data <= {wdata, wbuf[2], wbuf[1], wbuf[0]};
    end
  end

  // Write buffer: one word per short write, refilled after programming
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_buf
      always_ff @(posedge sys_clk)
      begin
        if (srst)
          wbuf[i] <= `FSPS_BUF_ERASED;
        else if (busy_now && tmr_expire && !op_erase)
          wbuf[i] <= `FSPS_BUF_ERASED;
        else if (state == SEQ_IDLE && (start_short || start_long) &&
                 addr_lo[1:0] == 2'(i))
          wbuf[i] <= wdata;
      end
    end
  endgenerate

  // External access gates from the code-protect straps
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ext_data_access_ok <= 1'b0;
      ext_prog_access_ok <= 1'b0;
      ext_prog_write_ok <= 1'b0;
    end
    else
    begin
      ext_data_access_ok <= !pins_sync[1];
      ext_prog_access_ok <= !pins_sync[0];
      ext_prog_write_ok <= !pins_sync[1] && !pins_sync[0];
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_short_go;
    start_short |=> go ##1 !go;
  endproperty
  a_short_go: assert property (p_short_go)
    else $error("short write go bit not cleared after one cycle");

  property p_long_slots;
    start_long |=> !cpu_discard ##1 cpu_discard ##1 cpu_stall;
  endproperty
  a_long_slots: assert property (p_long_slots)
    else $error("long write slot order wrong");

  property p_erase_stall;
    start_erase |=> cpu_discard [*2] ##1 (cpu_stall && flash_erase);
  endproperty
  a_erase_stall: assert property (p_erase_stall)
    else $error("erase did not stall the cpu");

  property p_done;
    ($fell(cpu_stall) && !$past(srst)) |-> done_flag && !go;
  endproperty
  a_done: assert property (p_done)
    else $error("completion did not set done and clear go");

  property p_program_unlock_enable;
    (wr_ctl && !ctl_program_unlock_enable && !go) |=> !go;
  endproperty
  a_program_unlock_enable: assert property (p_program_unlock_enable)
    else $error("go set without write enable");

  property p_unarmed;
    (wr_ctl && key != KEY_ARMED && !go) |=> !go;
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("go set without unlock sequence");

  property p_pwrt;
    (wr_ctl && pwrt_running && !go) |=> !go;
  endproperty
  a_pwrt: assert property (p_pwrt)
    else $error("write started during power-up lockout");

  property p_protect;
    (wr_ctl && wp_blocks(word_addr, wp_s) && !go) |=> !go;
  endproperty
  a_protect: assert property (p_protect)
    else $error("write started in protected segment");

  property p_buf_reset;
    ($fell(flash_program) && !$past(srst)) |->
      wbuf[0] == `FSPS_BUF_ERASED &&
      wbuf[3] == `FSPS_BUF_ERASED;
  endproperty
  a_buf_reset: assert property (p_buf_reset)
    else $error("buffer not refilled after long write");

  property p_abort;
    @(posedge sys_clk) disable iff (por_s) (srst && busy_now) |=> ctl_abort;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort flag not set by reset during cycle");

  c_short: cover property (start_short);
  c_long: cover property (start_long ##1 1'b1 [*3] ##0 cpu_stall);
  c_erase: cover property ($fell(flash_erase));
  c_abort: cover property (srst && busy_now);

endmodule : fsps_core

// >>> hdl/fsps_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module fsps_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] stage;

  // First stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      stage <= '0;
      level <= '0;
    end
    else
    begin
      stage <= pin;
      level <= stage;
    end
  end
endmodule : fsps_sync

// >>> hdl/fsps_timer.sv
// Loadable down-counter used for program cycles and power-up lockout
`timescale 1ns/10ps
module fsps_timer #(
  parameter int W = 24
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic running,
  output logic expire
);
  logic [W-1:0] cnt;

  // Load wins over the countdown so a restart is never lost
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      cnt <= '0;
    else if (load)
      cnt <= count;
    else if (cnt != '0)
      cnt <= cnt - W'(1);
  end

  // Expire marks the last counted cycle
  assign running = (cnt != '0);
  assign expire = (cnt == W'(1));
endmodule : fsps_timer

// >>> pkg/fsps_defs.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define FSPS_IDX_FLAG2 9'h00D
`define FSPS_IDX_ENA2 9'h08D
`define FSPS_IDX_DATA_LO 9'h10C
`define FSPS_IDX_ADDR_LO 9'h10D
`define FSPS_IDX_DATA_HI 9'h10E
`define FSPS_IDX_ADDR_HI 9'h10F
`define FSPS_IDX_CTL 9'h18C
`define FSPS_IDX_KEY 9'h18D

// Control register fields
`define FSPS_CTL_PGD 7
`define FSPS_CTL_FREE 4
`define FSPS_CTL_ABORT 3
`define FSPS_CTL_PROGRAM_UNLOCK_ENABLE 2
`define FSPS_CTL_GO 1
// Done flag and its enable sit at bit 4 of their registers
`define FSPS_DONE_BIT 4

// Unlock keys and buffer value after a long write
`define FSPS_KEY_FIRST 8'h55
`define FSPS_KEY_SECOND 8'hAA
`define FSPS_BUF_ERASED 14'h3FFF
`define FSPS_REG_RESET 8'h00

// Write-protect limits: addresses below the limit are protected
`define FSPS_WP_LIMIT_10 16'h0200
`define FSPS_WP_LIMIT_01 16'h0400
`define FSPS_WP_LIMIT_00 16'h0800

// Timing
`define FSPS_CLK_MHZ 100
`define FSPS_PROG_TIME_US 2000
`define FSPS_PWRT_TIME_MS 72
`define FSPS_PROG_CYCLES (`FSPS_PROG_TIME_US * `FSPS_CLK_MHZ)
`define FSPS_PWRT_CYCLES (`FSPS_PWRT_TIME_MS * 1000 * `FSPS_CLK_MHZ)

`endif

// >>> pkg/fsps_pkg.sv
// Types shared by the self-program sequencer
package fsps_pkg;

  // Sequence of one go-bit cycle
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_SHORT,
    SEQ_SETUP,
    SEQ_EXEC,
    SEQ_DISCARD,
    SEQ_BUSY
  } fsps_seq_t;

  // Progress through the unlock keys
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_FIRST,
    KEY_ARMED
  } fsps_key_t;

endpackage : fsps_pkg
